// >>> verilog/tape_reader_pkg.sv
// Purpose: shared constants for the paper tape reader sequencer
// Assumes: 50 MHz system clock
// Notes:   command, status and timing layout used by the sequencer
package tape_reader_pkg;

	// register map (word index on i_addr)
	localparam logic [1:0]  ADDR_CMD_DATA = 2'h0;
	localparam logic [1:0]  ADDR_STATUS   = 2'h1;

	// command word fields
	localparam int          CMD_ENTRY_LSB = 4;
	localparam int          CMD_ENTRY_MSB = 7;
	localparam int          CMD_BEGIN_BIT = 9;
	localparam int          CMD_SWRST_BIT = 15;

	// status word fields
	localparam int          ST_DATA_RDY   = 0;
	localparam int          ST_SYS_RDY    = 1;
	localparam int          ST_TERM_CNT   = 2;
	localparam int          ST_NOT_READY  = 3;
	localparam int          ST_BUSY       = 4;
	localparam int          ST_LEFT       = 5;
	localparam int          STATUS_W      = 6;

	// reset values
	localparam logic [15:0] RD_DATA_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	// timing
	localparam int          CLK_PERIOD_NS = 20;
	localparam int          SWRST_NS      = 250;
	localparam int          SWRST_CYC     = (SWRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SWRST_CNT     = 4'(SWRST_CYC);

	// sequence addresses
	typedef enum logic [3:0] {
		SQ_IDLE    = 4'h0,
		SQ_START_R = 4'h1,
		SQ_GAP     = 4'h2,
		SQ_CHECK   = 4'h3,
		SQ_CHAR    = 4'h4,
		SQ_SERVICE = 4'h5,
		SQ_START_L = 4'hA,
		SQ_EOB     = 4'hF
	} seq_state_t;

endpackage

// >>> verilog/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to i_clk_sys
// Notes:   output follows once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
	parameter int              W       = 1,
	parameter logic [W-1:0]    RST_VAL = '0
) (
	// clock and reset
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_n,
	// pins in, filtered level out
	input  wire logic [W-1:0]  i_pin,
	output logic      [W-1:0]  o_level
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] level_d;

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign level_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & o_level);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_level <= RST_VAL;
		end else begin
			o_level <= level_d;
		end
	end

endmodule

// >>> verilog/tape_reader_seq.sv
// Purpose: sequencer between host channel distributor and paper tape reader
// Assumes: single 50 MHz clock, host port on the same clock
// Notes:   reader pins pass pin_sync before any decision
//
// Contract
// - status read returns full six-bit status on data bits 0..5 next cycle
// - status answered in every sequence state
// - sixteen sequence addresses; begin command jumps straight to its entry address
// - reset or idle command puts sequencer in idle, waiting for begin
// - start state drives tape, waits for character-position line false
// - between characters, reader not online gives immediate block end interrupt
// - online: wait for character position true, then data service interrupt
// - without terminal count, repeat drive, observe, test, interrupt per byte
// - enter state F with block end interrupt on completion or error
// - decisions use logical truth of each line, not its polarity
// - rightward and leftward drive outputs are active low
// - reset output active low from switch or 250 ns software pulse
// - reader online line active low, tested before every byte
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module tape_reader_seq (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// register port
	input  wire logic [1:0]  i_addr,
	input  wire logic [15:0] i_wr_data,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rd_data,
	// channel distributor
	input  wire logic        i_term_count,
	input  wire logic        i_reset_sw_n,
	output logic             o_data_svc_int,
	output logic             o_block_end_interrupt,
	output logic             o_reset_n,
	// reader pins
	input  wire logic        i_data_ready,
	input  wire logic        i_sys_ready_n,
	input  wire logic [7:0]  i_tape_data,
	output logic             o_drive_right_n,
	output logic             o_drive_left_n
);

	tape_reader_pkg::seq_state_t state_q;
	tape_reader_pkg::seq_state_t state_d;
	logic                        data_ready;
	logic                        sys_ready_n;
	logic                        reset_sw_n;
	logic [7:0]                  tape_data;
	logic                        cmd_wr;
	logic                        cmd_begin;
	logic                        cmd_idle;
	logic                        cmd_swrst;
	logic                        byte_taken;
	logic                        left_q;
	logic                        term_q;
	logic                        err_q;
	logic [7:0]                  byte_q;
	logic [3:0]                  rst_cnt_q;
	logic [tape_reader_pkg::STATUS_W-1:0] status;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	pin_sync #(.W(1), .RST_VAL(1'b0)) u_sync_dr (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_data_ready),
		.o_level   (data_ready)
	);
	pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_sr (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_sys_ready_n),
		.o_level   (sys_ready_n)
	);
	pin_sync #(.W(1), .RST_VAL(1'b1)) u_sync_sw (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_reset_sw_n),
		.o_level   (reset_sw_n)
	);
	pin_sync #(.W(8), .RST_VAL(tape_reader_pkg::BYTE_RST)) u_sync_data (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_pin     (i_tape_data),
		.o_level   (tape_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// command decode
	assign cmd_wr     = i_wr && (i_addr == tape_reader_pkg::ADDR_CMD_DATA);
	assign cmd_swrst  = cmd_wr && i_wr_data[tape_reader_pkg::CMD_SWRST_BIT];
	assign cmd_begin  = cmd_wr && !cmd_swrst && i_wr_data[tape_reader_pkg::CMD_BEGIN_BIT];
	assign cmd_idle   = (cmd_wr && !cmd_begin) || !reset_sw_n;
	assign byte_taken = i_rd && (i_addr == tape_reader_pkg::ADDR_CMD_DATA)
		&& (state_q == tape_reader_pkg::SQ_SERVICE);

	////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_d = state_q;
		if (cmd_idle) begin
			state_d = tape_reader_pkg::SQ_IDLE;
		end else if (cmd_begin) begin
			state_d = tape_reader_pkg::seq_state_t'(
				i_wr_data[tape_reader_pkg::CMD_ENTRY_MSB:tape_reader_pkg::CMD_ENTRY_LSB]);
		end else begin
			unique case (state_q)
				tape_reader_pkg::SQ_IDLE: begin
					state_d = tape_reader_pkg::SQ_IDLE;
				end
				tape_reader_pkg::SQ_START_R, tape_reader_pkg::SQ_START_L: begin
					state_d = tape_reader_pkg::SQ_GAP;
				end
				tape_reader_pkg::SQ_GAP: begin
					if (!data_ready) begin
						state_d = tape_reader_pkg::SQ_CHECK;
					end
				end
				tape_reader_pkg::SQ_CHECK: begin
					state_d = sys_ready_n ? tape_reader_pkg::SQ_EOB : tape_reader_pkg::SQ_CHAR;
				end
				tape_reader_pkg::SQ_CHAR: begin
					if (data_ready) begin
						state_d = tape_reader_pkg::SQ_SERVICE;
					end
				end
				tape_reader_pkg::SQ_SERVICE: begin
					if (byte_taken) begin
						state_d = (term_q || i_term_count) ? tape_reader_pkg::SQ_EOB : tape_reader_pkg::SQ_GAP;
					end
				end
				tape_reader_pkg::SQ_EOB: begin
					state_d = tape_reader_pkg::SQ_EOB;
				end
				default: begin
					state_d = tape_reader_pkg::SQ_EOB;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= tape_reader_pkg::SQ_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// direction, terminal count and error flags
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			left_q <= 1'b0;
		end else if (state_d == tape_reader_pkg::SQ_START_L) begin
			left_q <= 1'b1;
		end else if (state_d == tape_reader_pkg::SQ_START_R) begin
			left_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			term_q <= 1'b0;
		end else if (i_term_count && state_q != tape_reader_pkg::SQ_IDLE) begin
			term_q <= 1'b1;
		end else if (cmd_begin) begin
			term_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_q <= 1'b0;
		end else if (state_q == tape_reader_pkg::SQ_CHECK && sys_ready_n && !cmd_idle && !cmd_begin) begin
			err_q <= 1'b1;
		end else if (cmd_begin) begin
			err_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			byte_q <= tape_reader_pkg::BYTE_RST;
		end else if (state_q == tape_reader_pkg::SQ_CHAR && data_ready) begin
			byte_q <= tape_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts and drive outputs
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_data_svc_int        <= 1'b0;
			o_block_end_interrupt <= 1'b0;
		end else begin
			o_data_svc_int        <= state_d == tape_reader_pkg::SQ_SERVICE && state_q != tape_reader_pkg::SQ_SERVICE;
			o_block_end_interrupt <= state_d == tape_reader_pkg::SQ_EOB && state_q != tape_reader_pkg::SQ_EOB;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_drive_right_n <= 1'b1;
			o_drive_left_n  <= 1'b1;
		end else begin
			o_drive_right_n <= !(state_d inside {tape_reader_pkg::SQ_START_R, tape_reader_pkg::SQ_GAP,
				tape_reader_pkg::SQ_CHECK, tape_reader_pkg::SQ_CHAR} && state_d != tape_reader_pkg::SQ_START_L
				&& (state_d == tape_reader_pkg::SQ_START_R || !left_q));
			o_drive_left_n  <= !(state_d inside {tape_reader_pkg::SQ_START_L, tape_reader_pkg::SQ_GAP,
				tape_reader_pkg::SQ_CHECK, tape_reader_pkg::SQ_CHAR}
				&& (state_d == tape_reader_pkg::SQ_START_L || left_q));
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_cnt_q <= 4'h0;
		end else if (cmd_swrst) begin
			rst_cnt_q <= tape_reader_pkg::SWRST_CNT;
		end else if (rst_cnt_q != 4'h0) begin
			rst_cnt_q <= rst_cnt_q - 4'h1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reset_n <= 1'b0;
		end else begin
			o_reset_n <= reset_sw_n && !cmd_swrst && (rst_cnt_q <= 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status and read data
	// status bits carry logical truth
	always_comb begin
		status = '0;
		status[tape_reader_pkg::ST_DATA_RDY]  = data_ready;
		status[tape_reader_pkg::ST_SYS_RDY]   = !sys_ready_n;
		status[tape_reader_pkg::ST_TERM_CNT]  = term_q;
		status[tape_reader_pkg::ST_NOT_READY] = err_q;
		status[tape_reader_pkg::ST_BUSY]      = state_q != tape_reader_pkg::SQ_IDLE;
		status[tape_reader_pkg::ST_LEFT]      = left_q;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= tape_reader_pkg::RD_DATA_RST;
		end else if (i_rd && i_addr == tape_reader_pkg::ADDR_STATUS) begin
			o_rd_data <= {10'h000, status};
		end else if (i_rd && i_addr == tape_reader_pkg::ADDR_CMD_DATA) begin
			o_rd_data <= {8'h00, byte_q};
		end else begin
			o_rd_data <= tape_reader_pkg::RD_DATA_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	property p_status_read;
		logic [5:0] s;
		(i_rd && i_addr == tape_reader_pkg::ADDR_STATUS, s = status) |=> o_rd_data == {10'h000, s};
	endproperty
	a_status_read: assert property (p_status_read) else $error("status word not returned");
	property p_begin_jump;
		logic [3:0] e;
		(cmd_begin && reset_sw_n, e = i_wr_data[tape_reader_pkg::CMD_ENTRY_MSB:tape_reader_pkg::CMD_ENTRY_LSB])
			|=> state_q == e;
	endproperty
	a_begin_jump: assert property (p_begin_jump) else $error("begin did not jump to entry");
	property p_idle_cmd;
		cmd_idle |=> state_q == tape_reader_pkg::SQ_IDLE && o_drive_right_n && o_drive_left_n;
	endproperty
	a_idle_cmd: assert property (p_idle_cmd) else $error("idle command ignored");
	property p_start_drive;
		state_q == tape_reader_pkg::SQ_GAP && !left_q |-> !o_drive_right_n && o_drive_left_n;
	endproperty
	a_start_drive: assert property (p_start_drive) else $error("rightward drive missing");
	property p_not_ready_end;
		state_q == tape_reader_pkg::SQ_CHECK && sys_ready_n && !cmd_wr && reset_sw_n |=>
			state_q == tape_reader_pkg::SQ_EOB && o_block_end_interrupt && err_q;
	endproperty
	a_not_ready_end: assert property (p_not_ready_end) else $error("not ready did not end block");

	property p_char_service;
		state_q == tape_reader_pkg::SQ_CHAR && data_ready && !cmd_wr && reset_sw_n |=>
			o_data_svc_int && state_q == tape_reader_pkg::SQ_SERVICE;
	endproperty
	a_char_service: assert property (p_char_service) else $error("no data service interrupt");

	property p_repeat;
		byte_taken && !term_q && !i_term_count && !cmd_wr && reset_sw_n |=> state_q == tape_reader_pkg::SQ_GAP;
	endproperty
	a_repeat: assert property (p_repeat) else $error("byte cycle not repeated");

	property p_term_end;
		byte_taken && i_term_count && !cmd_wr && reset_sw_n |=>
			$rose(o_block_end_interrupt) ##1 !o_block_end_interrupt;
	endproperty
	a_term_end: assert property (p_term_end) else $error("terminal count did not end block");

	property p_drive_off;
		state_q inside {tape_reader_pkg::SQ_IDLE, tape_reader_pkg::SQ_EOB} && $stable(state_q) |->
			o_drive_right_n && o_drive_left_n;
	endproperty
	a_drive_off: assert property (p_drive_off) else $error("drive active while idle");

	property p_swrst_pulse;
		cmd_swrst && rst_cnt_q == 4'h0 && reset_sw_n |=> (!o_reset_n)[*8] ##1 (!o_reset_n)[*5]
			##1 (o_reset_n || cmd_swrst || !reset_sw_n);
	endproperty
	a_swrst_pulse: assert property (p_swrst_pulse) else $error("reset pulse length wrong");

	c_right_read: cover property (state_q == tape_reader_pkg::SQ_START_R ##[1:200] o_data_svc_int);
	c_left_read: cover property (state_q == tape_reader_pkg::SQ_START_L ##[1:200] o_data_svc_int);
	c_error_end: cover property (err_q && o_block_end_interrupt);
	c_term_end: cover property (term_q && o_block_end_interrupt);

endmodule

// >>> tb/tape_reader_model.sv
// Purpose: behavioural paper tape reader mechanism
// Assumes: tape moves only while a drive line is active
// Notes:   step length sets prompt or slow character timing
`timescale 1ns/10ps
module tape_reader_model (
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	// drive lines and bench controls
	input  wire logic       i_drive_right_n,
	input  wire logic       i_drive_left_n,
	input  wire logic       i_online,
	input  wire logic [7:0] i_step_cyc,
	// reader status and data
	output logic            o_data_ready,
	output logic            o_sys_ready_n,
	output logic      [7:0] o_tape_data
);
	logic [7:0] pos_q;
	logic [7:0] cnt_q;
	logic [7:0] pos_d;

	////////////////////////////////////////////////////////////////
	assign pos_d = !i_drive_right_n ? pos_q + 8'h01 : pos_q - 8'h01;
	assign o_sys_ready_n = !i_online;

	////////////////////////////////////////////////////////////////
	// position and data
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos_q        <= 8'h10;
			cnt_q        <= 8'h00;
			o_data_ready <= 1'b1;
			o_tape_data  <= 8'h10 ^ 8'hA5;
		end else if (!i_drive_right_n || !i_drive_left_n) begin
			if (cnt_q < i_step_cyc) begin
				cnt_q <= cnt_q + 8'h01;
			end else begin
				cnt_q <= 8'h00;
				if (o_data_ready) begin
					o_data_ready <= 1'b0;
					o_tape_data  <= ~o_tape_data;
				end else begin
					pos_q        <= pos_d;
					o_data_ready <= 1'b1;
					o_tape_data  <= pos_d ^ 8'hA5;
				end
			end
		end
	end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the tape reader sequencer
// Assumes: 50 MHz clock, reader model on the far side
// Notes:   one task per scenario
`timescale 1ns/10ps
module tb;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [1:0]  i_addr = 2'h0;
	logic [15:0] i_wr_data = 16'h0000;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_term_count = 1'b0;
	logic        i_reset_sw_n = 1'b1;
	logic        online = 1'b1;
	logic [7:0]  step_cyc = 8'h06;
	logic [15:0] o_rd_data;
	logic        o_data_svc_int;
	logic        o_block_end_interrupt;
	logic        o_reset_n;
	logic        data_ready;
	logic        sys_ready_n;
	logic [7:0]  tape_data;
	logic        o_drive_right_n;
	logic        o_drive_left_n;
	logic [7:0]  pos = 8'h10;
	int          bad_count = 0;
	int          tests_run = 0;

	always #10 i_clk_sys = ~i_clk_sys;

	tape_reader_seq tape_reader_seq_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_term_count(i_term_count),
		.i_reset_sw_n(i_reset_sw_n), .o_data_svc_int(o_data_svc_int),
		.o_block_end_interrupt(o_block_end_interrupt), .o_reset_n(o_reset_n), .i_data_ready(data_ready),
		.i_sys_ready_n(sys_ready_n), .i_tape_data(tape_data), .o_drive_right_n(o_drive_right_n),
		.o_drive_left_n(o_drive_left_n));

	tape_reader_model tape_reader_model_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_drive_right_n(o_drive_right_n), .i_drive_left_n(o_drive_left_n), .i_online(online),
		.i_step_cyc(step_cyc), .o_data_ready(data_ready), .o_sys_ready_n(sys_ready_n), .o_tape_data(tape_data));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr    <= a;
		i_wr_data <= d;
		i_wr      <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		d = o_rd_data;
	endtask

	// 1 data service, 2 block end, 0 none
	task automatic wait_int(output logic [1:0] w);
		w = 2'd0;
		for (int i = 0; i < 400 && w == 2'd0; i++) begin
			@(negedge i_clk_sys);
			if (o_data_svc_int === 1'b1) w = 2'd1;
			else if (o_block_end_interrupt === 1'b1) w = 2'd2;
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		repeat (5) @(negedge i_clk_sys);
		chk({o_drive_left_n, o_drive_right_n, o_reset_n, o_data_svc_int, o_block_end_interrupt}, 16'h0018);
		chk(o_rd_data, 16'h0000);
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		repeat (8) @(posedge i_clk_sys);
	endtask

	task automatic t_idle_status();
		logic [15:0] d;
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d, 16'h0003);
		rd(2'h2, d);
		chk(d, 16'h0000);
	endtask

	task automatic t_run(input logic left, input int nbytes);
		logic [15:0] d;
		logic [1:0]  w;
		wr(tape_reader_pkg::ADDR_CMD_DATA, left ? 16'h02A0 : 16'h0210);
		repeat (2) @(negedge i_clk_sys);
		chk({o_drive_left_n, o_drive_right_n}, left ? 16'h0001 : 16'h0002);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[5:4], {left, 1'b1});
		for (int n = 0; n < nbytes; n++) begin
			wait_int(w);
			chk(w, 16'h0001);
			if (n == nbytes - 1) @(posedge i_clk_sys) i_term_count <= 1'b1;
			rd(tape_reader_pkg::ADDR_CMD_DATA, d);
			pos = left ? pos - 8'h01 : pos + 8'h01;
			chk(d, {8'h00, pos ^ 8'hA5});
		end
		chk(16'(o_block_end_interrupt), 16'h0001);
		repeat (2) @(negedge i_clk_sys);
		chk({o_drive_left_n, o_drive_right_n}, 16'h0003);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[4:2], 16'h0005);
		@(posedge i_clk_sys) i_term_count <= 1'b0;
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h0000);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[4], 1'b0);
	endtask

	task automatic t_not_ready();
		logic [15:0] d;
		logic [1:0]  w;
		step_cyc <= 8'd40;
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h0210);
		online <= 1'b0;
		wait_int(w);
		chk(w, 16'h0002);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[4:1], 16'h000C);
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h0000);
		online <= 1'b1;
	endtask

	task automatic t_sw_reset();
		logic [15:0] d;
		int          lows;
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h0210);
		repeat (5) @(negedge i_clk_sys);
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h8000);
		@(negedge i_clk_sys);
		lows = 0;
		while (o_reset_n === 1'b0 && lows < 40) begin
			lows++;
			@(negedge i_clk_sys);
		end
		chk(16'(lows), 16'(tape_reader_pkg::SWRST_CYC));
		chk({o_drive_left_n, o_drive_right_n}, 16'h0003);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[4], 1'b0);
	endtask

	task automatic t_switch_reset();
		logic [15:0] d;
		wr(tape_reader_pkg::ADDR_CMD_DATA, 16'h0210);
		repeat (4) @(posedge i_clk_sys);
		i_reset_sw_n <= 1'b0;
		repeat (7) @(negedge i_clk_sys);
		chk({o_reset_n, o_drive_left_n, o_drive_right_n}, 16'h0003);
		@(posedge i_clk_sys) i_reset_sw_n <= 1'b1;
		repeat (7) @(negedge i_clk_sys);
		chk(o_reset_n, 1'b1);
		rd(tape_reader_pkg::ADDR_STATUS, d);
		chk(d[4], 1'b0);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		t_reset();
		t_idle_status();
		t_run(1'b0, 3);
		t_run(1'b1, 2);
		t_not_ready();
		t_sw_reset();
		t_switch_reset();
		t_run(1'b0, 1);
		print_verdict();
	end

	initial begin
		#200000;
		bad_count++;
		$display("FAIL %0t watchdog expired", $time);
		print_verdict();
	end
endmodule
